// [design/sdc_params.svh]
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// register offsets, six bit address space
`define SDC_OFS_REVISION 6'h01
`define SDC_OFS_INT_CAUSE 6'h02
`define SDC_OFS_CHECKSUM 6'h03
`define SDC_OFS_MISC 6'h04
`define SDC_OFS_COMP 6'h05
`define SDC_OFS_GLOBAL 6'h1a
`define SDC_OFS_IN_EN 6'h1b
`define SDC_OFS_SRC_SINK 6'h1c
`define SDC_OFS_WET_LOW 6'h1d
`define SDC_OFS_WET_HIGH 6'h1e
`define SDC_OFS_CLN_TIME 6'h1f
`define SDC_OFS_CLN_SEL 6'h20
`define SDC_OFS_THRESH 6'h21
`define SDC_OFS_IRQ_A 6'h22
`define SDC_OFS_IRQ_B 6'h23
`define SDC_OFS_IRQ_GLB 6'h24

// serial frame layout
`define SDC_FRAME_BITS 6'd32
`define SDC_FRAME_OVER 6'd33
`define SDC_FRM_WRITE 31
`define SDC_FRM_ADDR_HI 30
`define SDC_FRM_ADDR_LO 25
`define SDC_FRM_DATA_HI 24
`define SDC_FRM_DATA_LO 1

// setup fields: global, cleaning timing and wetting level
`define SDC_CFG_POLL_EN 0
`define SDC_CFG_PERIOD_HI 4
`define SDC_CFG_PERIOD_LO 1
`define SDC_CFG_ACTIVE_HI 8
`define SDC_CFG_ACTIVE_LO 5
`define SDC_CLN_PULSE_HI 6
`define SDC_CLN_PULSE_LO 4
`define SDC_WLH_AUTO_HI 22
`define SDC_WLH_AUTO_LO 21
`define SDC_AUTO_OFF 2'h3
`define SDC_WL_CODES 15

// interrupt cause bits
`define SDC_INT_POR 0
`define SDC_INT_LEN 1
`define SDC_INT_PAR 2
`define SDC_INT_SSC 3
`define SDC_INT_TSD 4
`define SDC_INT_TW 5
`define SDC_INT_OV 6
`define SDC_INT_UV 7
`define SDC_INT_CRC 8
`define SDC_INT_CHK 13
`define SDC_INT_HW_MASK 24'h0021f8

// reset values
`define SDC_INT_RESET 24'h000001
`define SDC_CRC_RESET 24'h00ffff
`define SDC_CFG_RESET 24'h000000

`endif

// [design/sdc_pkg.sv]
`default_nettype none
package sdc_pkg;
    // outcome of one completed serial frame
    typedef enum logic [1:0] {
        v_none,
        v_length,
        v_parity,
        v_ok
    } sdc_verdict_t;
    typedef logic [23:0] sdc_word_t;
endpackage
`default_nettype wire

// [design/sdc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module sdc_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_q;

    // two stage level synchroniser; only q_out may be looked at
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [design/sdc_spi_link.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sdc_params.svh"
module sdc_spi_link (
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic [31:0] resp_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic [31:0] frame_out,
    output logic [5:0] count_out
);
    logic start_q;
    logic [31:0] tx_q;

    ////////////////////////////////////////////////////////////////////////
    // frame start marker: raised while select is high, dropped on the
    // first serial clock; the clock stands still between frames, so the
    // select level is the only thing that can arm the next frame
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            start_q <= 1'b1;
        end else begin
            start_q <= 1'b0;
        end
    end

    // output driver follows the frame, released as select rises
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            miso_oe_out <= 1'b0;
        end else begin
            miso_oe_out <= 1'b1;
        end
    end

    // answer bit, changes after each rising edge, host samples falling
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            miso_out <= 1'b0;
        end else if (start_q) begin
            miso_out <= resp_in[31];
        end else begin
            miso_out <= tx_q[31];
        end
    end

    // answer word, stable in the other domain for the whole frame
    always_ff @(posedge sclk_in) begin
        if (start_q) begin
            tx_q <= {resp_in[30:0], 1'b0};
        end else begin
            tx_q <= {tx_q[30:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive shifter and bit counter; both are left alone after the last
    // edge so the register side can pick them up once select has risen
    always_ff @(posedge sclk_in) begin
        if (start_q) begin
            frame_out <= {31'h0, mosi_in};
            count_out <= 6'd1;
        end else begin
            frame_out <= {frame_out[30:0], mosi_in};
            if (count_out != `SDC_FRAME_OVER) begin // saturate, long is long
                count_out <= count_out + 6'd1;
            end
        end
    end
endmodule
`default_nettype wire

// [design/sdc_switch_regs.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sdc_params.svh"
module sdc_switch_regs #(
    parameter logic [23:0] REVISION = 24'h000a50 // arbitrary value
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic int_n_out,
    input wire logic [23:0] hw_event_in,
    input wire logic [23:0] misc_status_in,
    input wire logic [23:0] comp_status_in,
    input wire logic [23:0] crc_in,
    input wire logic crc_valid_in,
    output logic [23:0] global_setup_out,
    output logic [23:0] input_enables_out,
    output logic [23:0] source_sink_out,
    output logic [23:0] wetting_level_low_out,
    output logic [23:0] wetting_level_high_out,
    output logic [23:0] cleaning_timing_out,
    output logic [23:0] cleaning_input_bit_out,
    output logic [23:0] thresholds_out,
    output logic [23:0] irq_enable_a_out,
    output logic [23:0] irq_enable_b_out,
    output logic [23:0] global_irq_enable_out,
    output logic [`SDC_WL_CODES-1:0] autoscale_out
);
    logic cs_sync;
    logic cs_prev_q;
    logic frame_done;
    logic [31:0] frame;
    logic [5:0] count;
    logic [31:0] resp_q;
    logic [31:0] resp_d;
    logic [5:0] addr;
    logic [23:0] wdata;
    logic is_write;
    sdc_pkg::sdc_verdict_t verdict;
    sdc_pkg::sdc_word_t rd_data;
    sdc_pkg::sdc_word_t int_stat_q;
    sdc_pkg::sdc_word_t int_stat_d;
    sdc_pkg::sdc_word_t checksum_q;
    logic int_n_q;
    logic wr_ok;
    logic rd_int;
    logic auto_en;
    logic [44:0] wl_all;
    logic [`SDC_WL_CODES-1:0] auto_q;

    ////////////////////////////////////////////////////////////////////////
    // serial link on its own clock, select crossed into this domain
    sdc_spi_link u_link (
        .sclk_in(sclk_in),
        .cs_n_in(cs_n_in),
        .mosi_in(mosi_in),
        .resp_in(resp_q),
        .miso_out(miso_out),
        .miso_oe_out(miso_oe_out),
        .frame_out(frame),
        .count_out(count)
    );

    sdc_sync #(
        .RESET_VAL(1'b1)
    ) u_cs_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(cs_n_in),
        .q_out(cs_sync)
    );

    // frame end seen on synchronised select; the link clock is quiet by
    // then, so shifter and counter are static while they are sampled
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cs_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_sync;
        end
    end
    assign frame_done = cs_sync & ~cs_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // frame checks: length first, then parity
    assign addr = frame[`SDC_FRM_ADDR_HI:`SDC_FRM_ADDR_LO];
    assign wdata = frame[`SDC_FRM_DATA_HI:`SDC_FRM_DATA_LO];
    assign is_write = frame[`SDC_FRM_WRITE];
    always_comb begin
        verdict = sdc_pkg::v_none;
        if (frame_done && count != 6'd0) begin
            if (count != `SDC_FRAME_BITS) begin
                verdict = sdc_pkg::v_length;
            end else if (~^frame) begin
                verdict = sdc_pkg::v_parity;
            end else begin
                verdict = sdc_pkg::v_ok;
            end
        end
    end
    assign wr_ok = (verdict == sdc_pkg::v_ok) & is_write;
    assign rd_int = (verdict == sdc_pkg::v_ok) & ~is_write &
        (addr == `SDC_OFS_INT_CAUSE);

    // read mux; holes in the map answer zero
    always_comb begin
        case (addr)
            `SDC_OFS_REVISION: rd_data = REVISION;
            `SDC_OFS_INT_CAUSE: rd_data = int_stat_q;
            `SDC_OFS_CHECKSUM: rd_data = checksum_q;
            `SDC_OFS_MISC: rd_data = misc_status_in;
            `SDC_OFS_COMP: rd_data = comp_status_in;
            `SDC_OFS_GLOBAL: rd_data = global_setup_out;
            `SDC_OFS_IN_EN: rd_data = input_enables_out;
            `SDC_OFS_SRC_SINK: rd_data = source_sink_out;
            `SDC_OFS_WET_LOW: rd_data = wetting_level_low_out;
            `SDC_OFS_WET_HIGH: rd_data = wetting_level_high_out;
            `SDC_OFS_CLN_TIME: rd_data = cleaning_timing_out;
            `SDC_OFS_CLN_SEL: rd_data = cleaning_input_bit_out;
            `SDC_OFS_THRESH: rd_data = thresholds_out;
            `SDC_OFS_IRQ_A: rd_data = irq_enable_a_out;
            `SDC_OFS_IRQ_B: rd_data = irq_enable_b_out;
            `SDC_OFS_IRQ_GLB: rd_data = global_irq_enable_out;
            default: rd_data = 24'h000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; only a checked write frame lands here, and
    // a write to any other offset falls through untouched
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            global_setup_out <= `SDC_CFG_RESET;
            input_enables_out <= `SDC_CFG_RESET;
            source_sink_out <= `SDC_CFG_RESET;
            wetting_level_low_out <= `SDC_CFG_RESET;
            wetting_level_high_out <= `SDC_CFG_RESET;
            cleaning_timing_out <= `SDC_CFG_RESET;
            cleaning_input_bit_out <= `SDC_CFG_RESET;
            thresholds_out <= `SDC_CFG_RESET;
            irq_enable_a_out <= `SDC_CFG_RESET;
            irq_enable_b_out <= `SDC_CFG_RESET;
            global_irq_enable_out <= `SDC_CFG_RESET;
        end else if (wr_ok) begin
            case (addr)
                `SDC_OFS_GLOBAL: global_setup_out <= wdata;
                `SDC_OFS_IN_EN: input_enables_out <= wdata;
                `SDC_OFS_SRC_SINK: source_sink_out <= wdata;
                `SDC_OFS_WET_LOW: wetting_level_low_out <= wdata;
                `SDC_OFS_WET_HIGH: wetting_level_high_out <= wdata;
                `SDC_OFS_CLN_TIME: cleaning_timing_out <= wdata;
                `SDC_OFS_CLN_SEL: cleaning_input_bit_out <= wdata;
                `SDC_OFS_THRESH: thresholds_out <= wdata;
                `SDC_OFS_IRQ_A: irq_enable_a_out <= wdata;
                `SDC_OFS_IRQ_B: irq_enable_b_out <= wdata;
                `SDC_OFS_IRQ_GLB: global_irq_enable_out <= wdata;
                default: ;
            endcase
        end
    end

    // checksum result, loaded by the checksum engine when it finishes
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            checksum_q <= `SDC_CRC_RESET;
        end else if (crc_valid_in) begin
            checksum_q <= crc_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt cause: read clears, then new events are or-ed in so an
    // event in the clearing cycle survives
    always_comb begin
        int_stat_d = int_stat_q;
        if (rd_int) begin
            int_stat_d = 24'h000000;
        end
        int_stat_d = int_stat_d | (hw_event_in & `SDC_INT_HW_MASK);
        if (verdict == sdc_pkg::v_length) begin
            int_stat_d[`SDC_INT_LEN] = 1'b1;
        end
        if (verdict == sdc_pkg::v_parity) begin
            int_stat_d[`SDC_INT_PAR] = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            int_stat_q <= `SDC_INT_RESET;
        end else begin
            int_stat_q <= int_stat_d;
        end
    end

    // pin low while any cause stands, released the cycle after the
    // select rise of the reading frame is seen here
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            int_n_q <= 1'b0;
        end else begin
            int_n_q <= ~|int_stat_d;
        end
    end
    assign int_n_out = int_n_q;

    ////////////////////////////////////////////////////////////////////////
    // answer word for the next frame: flags, data read by this frame, odd
    // parity; it changes only at frame end, so the link sees it static
    always_comb begin
        resp_d = resp_q;
        if (frame_done) begin
            resp_d[31] = int_stat_d[`SDC_INT_POR];
            resp_d[30] = int_stat_d[`SDC_INT_LEN];
            resp_d[29] = int_stat_d[`SDC_INT_PAR];
            resp_d[28] = int_stat_d[`SDC_INT_SSC];
            resp_d[27] = 1'b0;
            resp_d[26] = int_stat_d[`SDC_INT_TSD] | int_stat_d[`SDC_INT_TW];
            resp_d[25] = int_stat_d[`SDC_INT_OV] | int_stat_d[`SDC_INT_UV] |
                int_stat_d[`SDC_INT_CRC] | int_stat_d[`SDC_INT_CHK];
            resp_d[24:1] = (verdict == sdc_pkg::v_ok) ? rd_data : 24'h000000;
            resp_d[0] = ~^resp_d[31:1];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            resp_q <= 32'h80000000; // reset flag only, parity already odd
        end else begin
            resp_q <= resp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wetting auto-scaling per level code; any unmet condition just means
    // off, there is no error path for a misconfiguration
    assign auto_en = (wetting_level_high_out[`SDC_WLH_AUTO_HI:
        `SDC_WLH_AUTO_LO] != `SDC_AUTO_OFF) &
        ~global_setup_out[`SDC_CFG_POLL_EN];
    assign wl_all = {wetting_level_high_out[20:0], wetting_level_low_out};

    genvar gi;
    generate
        for (gi = 0; gi < `SDC_WL_CODES; gi = gi + 1) begin : g_auto
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    auto_q[gi] <= 1'b0;
                end else begin
                    auto_q[gi] <= auto_en & wl_all[3*gi+2];
                end
            end
        end
    endgenerate
    assign autoscale_out = auto_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    len_error_flag_a: assert property (
        verdict == sdc_pkg::v_length |=> int_stat_q[`SDC_INT_LEN] && !int_n_out)
        else $error("short or long frame not flagged");
    len_error_drop_a: assert property (
        frame_done && count != `SDC_FRAME_BITS |=> $stable(global_setup_out)
        && $stable(input_enables_out))
        else $error("bad length frame changed a register");
    parity_flag_a: assert property (
        frame_done && count == `SDC_FRAME_BITS && ~^frame
        |=> int_stat_q[`SDC_INT_PAR] && !int_n_out)
        else $error("even parity frame not flagged");
    parity_drop_a: assert property (
        verdict == sdc_pkg::v_parity |=> $stable(cleaning_timing_out)
        && $stable(wetting_level_high_out))
        else $error("bad parity frame changed a register");
    status_clear_a: assert property (
        rd_int && hw_event_in == 24'h000000 |=> int_n_out
        && int_stat_q == 24'h000000)
        else $error("interrupt cause read did not release");
    poll_period_a: assert property (
        wr_ok && addr == `SDC_OFS_GLOBAL |=> global_setup_out[4:1] ==
        $past(frame[5:2]))
        else $error("poll period field misplaced");
    active_time_a: assert property (
        wr_ok && addr == `SDC_OFS_GLOBAL |=> global_setup_out[8:5] ==
        $past(frame[9:6]))
        else $error("active sample field misplaced");
    poll_blocks_auto_a: assert property (
        global_setup_out[`SDC_CFG_POLL_EN] [*2] |-> autoscale_out == '0)
        else $error("auto-scaling active in polling mode");
    auto_disable_a: assert property (
        wetting_level_high_out[22:21] == 2'h3 |=> autoscale_out == '0)
        else $error("auto-scaling not disabled by code 11");
    auto_code_a: assert property (
        !wetting_level_low_out[2] |=> !autoscale_out[0])
        else $error("auto-scaling on a low current code");
    reserved_zero_a: assert property (
        verdict == sdc_pkg::v_ok && !is_write && addr > `SDC_OFS_IRQ_GLB
        |=> resp_q[24:1] == 24'h000000)
        else $error("reserved offset read not zero");

    good_write_c: cover property (wr_ok ##1 frame_done);
    length_err_c: cover property (verdict == sdc_pkg::v_length);
    parity_err_c: cover property (verdict == sdc_pkg::v_parity);
    int_read_c: cover property (rd_int ##1 int_n_out);
endmodule
`default_nettype wire

// [verification/sdc_host.sv]
`timescale 1ns/1ns
`default_nettype none
module sdc_host (
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic miso_oe_in
);
    //////////////////////////////////////////////////////////////////////
    // idle link: clock parked low, select high, data line low
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b0;
        mosi_out = 1'b0;
        // a clean select rise arms the link's frame start marker; a bare
        // time zero assignment may land before the link's processes wake
        #2 cs_n_out = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////
    // one frame of n bits, msb first, 12 ns link clock only inside frame;
    // bad flips the parity bit so a scenario can provoke a refusal
    task automatic send(input logic wr, input logic [5:0] a,
        input logic [23:0] d, input int n, input logic bad,
        output logic [31:0] r);
        logic [31:0] w;
        w = {wr, a, d, 1'b0};
        w[0] = ~(^w[31:1]) ^ bad; // odd count of ones
        r = 32'h0;
        cs_n_out = 1'b0;
        #5;
        for (int i = 0; i < n; i++) begin
            mosi_out = (i < 32) ? w[31 - i] : 1'b0;
            #6 sclk_out = 1'b1;
            #6 sclk_out = 1'b0;
            r = {r[30:0], miso_oe_in ? miso_in : 1'b0}; // sampled on fall
        end
        #4 cs_n_out = 1'b1;
        // released line shows the inverse so a stale bit never looks valid
        mosi_out = ~mosi_out;
        // long gap covers select synchronising and register update
        #80;
    endtask
endmodule
`default_nettype wire

// [verification/sdc_switch_regs_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sdc_params.svh"
module sdc_switch_regs_test;
    localparam logic [23:0] REV = 24'h000a50; // arbitrary value
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [23:0] hw_event_in = 24'h0;
    logic [23:0] misc_status_in = 24'h123456;
    logic [23:0] comp_status_in = 24'h654321;
    logic [23:0] crc_in = 24'h0;
    logic crc_valid_in = 1'b0;
    wire sclk, cs_n, mosi, miso, miso_oe, int_n_out;
    wire [23:0] gs, ie, ss, wl, wh, ct, ci, th, ia, ib, ig;
    wire [14:0] autoscale_out;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] r;

    //////////////////////////////////////////////////////////////////////
    sdc_switch_regs #(.REVISION(REV)) sdc_switch_regs_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_out(miso_oe), .int_n_out(int_n_out),
        .hw_event_in(hw_event_in), .misc_status_in(misc_status_in),
        .comp_status_in(comp_status_in), .crc_in(crc_in),
        .crc_valid_in(crc_valid_in), .global_setup_out(gs),
        .input_enables_out(ie), .source_sink_out(ss),
        .wetting_level_low_out(wl), .wetting_level_high_out(wh),
        .cleaning_timing_out(ct), .cleaning_input_bit_out(ci),
        .thresholds_out(th), .irq_enable_a_out(ia),
        .irq_enable_b_out(ib), .global_irq_enable_out(ig),
        .autoscale_out(autoscale_out));
    sdc_host sdc_host_i (.sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe));

    //////////////////////////////////////////////////////////////////////
    // clock, and a ceiling well above the roughly 4700 cycles needed
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            close_out();
        end
    end

    //////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        logic [31:0] q;
        sdc_host_i.send(1'b1, a, d, 32, 1'b0, q);
    endtask

    // data of a read comes back in the following frame
    task automatic rdc(input logic [5:0] a, input logic [23:0] exp);
        logic [31:0] q;
        sdc_host_i.send(1'b0, a, 24'h0, 32, 1'b0, q);
        sdc_host_i.send(1'b0, `SDC_OFS_REVISION, 24'h0, 32, 1'b0, q);
        chk({31'h0, ^q}, 32'h1); // answer parity odd
        chk({8'h0, q[24:1]}, {8'h0, exp});
    endtask

    task automatic pulse_event(input logic [23:0] e);
        @(negedge clk_in) hw_event_in = e;
        @(negedge clk_in) hw_event_in = 24'h0;
    endtask

    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk({31'h0, int_n_out}, 32'h0); // power-on cause pending
        sdc_host_i.send(1'b0, `SDC_OFS_REVISION, 24'h0, 32, 1'b0, r);
        chk(r, 32'h80000000);
        rdc(`SDC_OFS_REVISION, REV);
        rdc(`SDC_OFS_INT_CAUSE, 24'h000001); // read then cleared
        chk({31'h0, int_n_out}, 32'h1); // released after the read
        rdc(`SDC_OFS_INT_CAUSE, 24'h0);
        rdc(`SDC_OFS_CHECKSUM, 24'h00ffff);
        rdc(`SDC_OFS_MISC, 24'h123456);
        rdc(`SDC_OFS_COMP, 24'h654321);
        // every read-write register: reset zero, then holds a pattern
        for (logic [5:0] a = 6'h1a; a <= 6'h24; a++) begin
            rdc(a, 24'h0);
            wr(a, {4{a}});
            rdc(a, {4{a}});
        end
        chk({28'h0, gs[4:1]}, {28'h0, 4'hd}); // period field
        chk({28'h0, gs[8:5]}, {28'h0, 4'h4}); // active field
        chk({29'h0, ct[6:4]}, {29'h0, 3'h5}); // pulse field
        chk({8'h0, ig}, {8'h0, {4{6'h24}}});
        // reserved places read zero, read-only ignores writes
        wr(6'h10, 24'hffffff);
        rdc(6'h10, 24'h0);
        wr(6'h25, 24'hffffff);
        rdc(6'h25, 24'h0);
        wr(`SDC_OFS_CHECKSUM, 24'h000123);
        rdc(`SDC_OFS_CHECKSUM, 24'h00ffff);
        chk({8'h0, ig}, {8'h0, {4{6'h24}}}); // untouched by reserved
        // short and long frames are refused
        wr(`SDC_OFS_GLOBAL, 24'h000000);
        sdc_host_i.send(1'b1, `SDC_OFS_GLOBAL, 24'h00001e, 31, 1'b0, r);
        chk({31'h0, int_n_out}, 32'h0);
        chk({8'h0, gs}, 32'h0);
        rdc(`SDC_OFS_INT_CAUSE, 24'h000002);
        sdc_host_i.send(1'b1, `SDC_OFS_GLOBAL, 24'h00001e, 33, 1'b0, r);
        chk({8'h0, gs}, 32'h0);
        rdc(`SDC_OFS_INT_CAUSE, 24'h000002);
        // even count of ones is refused
        sdc_host_i.send(1'b1, `SDC_OFS_GLOBAL, 24'h00001e, 32, 1'b1, r);
        chk({31'h0, int_n_out}, 32'h0);
        chk({8'h0, gs}, 32'h0);
        rdc(`SDC_OFS_INT_CAUSE, 24'h000004);
        chk({31'h0, int_n_out}, 32'h1);
        // events and checksum load
        pulse_event(24'h000008);
        repeat (3) @(negedge clk_in);
        chk({31'h0, int_n_out}, 32'h0);
        rdc(`SDC_OFS_INT_CAUSE, 24'h000008);
        @(negedge clk_in) begin
            crc_in = 24'h00beef;
            crc_valid_in = 1'b1;
        end
        @(negedge clk_in) crc_valid_in = 1'b0;
        rdc(`SDC_OFS_CHECKSUM, 24'h00beef);
        // a legal continuous setup: inputs enabled before cleaning
        wr(`SDC_OFS_IN_EN, 24'h000003);
        wr(`SDC_OFS_CLN_SEL, 24'h000001);
        wr(`SDC_OFS_CLN_TIME, 24'h000010); // short pulse
        wr(`SDC_OFS_GLOBAL, 24'h000000); // continuous, margin kept
        // auto-scaling: codes 0, 7 and 8 high, code 1 low
        wr(`SDC_OFS_WET_LOW, 24'he0001c);
        wr(`SDC_OFS_WET_HIGH, 24'h600005);
        chk({17'h0, autoscale_out}, 32'h0); // control 2'b11
        wr(`SDC_OFS_WET_HIGH, 24'h000005);
        chk({17'h0, autoscale_out}, 32'h0181); // top bit codes only
        wr(`SDC_OFS_WET_HIGH, 24'h200005);
        chk({17'h0, autoscale_out}, 32'h0181);
        wr(`SDC_OFS_GLOBAL, 24'h00001f); // polling, long period
        chk({17'h0, autoscale_out}, 32'h0);
        chk({31'h0, int_n_out}, 32'h1); // no error flagged
        close_out();
    end
endmodule
`default_nettype wire
